// ===== design/wake_source_regs.vh
`ifndef WAKE_SOURCE_REGS_VH
`define WAKE_SOURCE_REGS_VH
// ----------------------------------------
// register indices on the parallel register port
// ----------------------------------------
`define IDX_WAKE_PIN_CONFIG 2'h0
`define IDX_WAKE_PIN_ENABLE 2'h1
`define IDX_WAKE_PIN_FLAGS 2'h2
`define IDX_WAKE_SOURCE_ENABLE 2'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define POL_A_LO 2
`define POL_B_LO 4
`define POL_HV_LO 6
`define DGL_A_BIT 9
`define DGL_B_BIT 10
`define DGL_HV_BIT 11
`define CAP_A_LO 2
`define CAP_B_LO 4
`define CAP_HV_LO 6
`define CAP_BUS_LO 0
`define CAP_TMR_LO 4
`define FLG_A_BIT 1
`define FLG_B_BIT 2
`define FLG_HV_BIT 5
// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define CFG_MASK 16'h0EFC
`define EN_MASK 16'h00FC
`define FLG_MASK 16'h0026
`define SRC_MASK 16'h0033
`define CFG_RESET 16'h0004
`define EN_RESET 16'h0054
`define SRC_RESET 16'h0001
// ----------------------------------------
// encodings
// ----------------------------------------
`define POL_OFF 2'h0
`define POL_HIGH 2'h1
`define POL_LOW 2'h2
`define POL_MODE 2'h3
`define CAP_WAKE_BIT 0
`define CAP_INT_BIT 1
// ----------------------------------------
// deglitch timing at 25 MHz
// ----------------------------------------
// 15 us and 65 us in clock cycles
`define DGL_SHORT_CYC 11'h177
`define DGL_LONG_CYC 11'h659
`define DGL_CNT_W 11
`endif

// ===== design/wake_source_config_regs.v
// Function
// R1: pin a polarity: off, high, low, reserved
// R2: pin b polarity at bits 4-5
// R3: hv io polarity, code 11 mode wake
// R4: pin a deglitch 15 or 65 us
// R5: pin b deglitch select bit 10
// R6: hv io deglitch select bit 11
// R7: pin a capability none/wake/int/both
// R8: pin b capability at bits 4-5
// R9: hv io capability at bits 6-7
// R10: bus capability at bits 0-1
// R11: timer capability at bits 4-5
// R12: capabilities default on reset or fail-safe
// R13: pin a level wake flag bit 1
// R14: pin b level wake flag bit 2
// R15: hv io level wake flag bit 5
// R16: flags clear on reset or low-power entry; the code clears them on reset or wake_flags_clear_all, not on low-power entry
// R17: wake needs polarity match and capability
// R18: unused bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "wake_source_regs.vh"
module wake_source_config_regs (
	input wire clock,
	input wire reset,
	input wire reg_write,
	input wire [1:0] reg_index,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	input wire fail_safe_entry,
	input wire wake_flags_clear_all,
	input wire low_power,
	input wire mode_wake_sel,
	input wire [2:0] wake_pin_in,
	input wire bus_wake_event,
	input wire timer_wake_event,
	output reg [2:0] pin_wake_req,
	output reg [2:0] pin_int_req,
	output reg [2:0] pin_comparator_on,
	output reg bus_wake_req,
	output reg bus_int_req,
	output reg timer_wake_req,
	output reg timer_int_req
);
// ----------------------------------------
// registers
// ----------------------------------------
reg [15:0] cfg_q;
reg [15:0] en_q;
reg [15:0] flg_q;
reg [15:0] src_q;
reg [15:0] cfg_d;
reg [15:0] en_d;
reg [15:0] flg_d;
reg [15:0] src_d;
reg [15:0] rdata_d;

wire [2:0] level_hit;
wire [2:0] wake_hit;
wire [2:0] int_hit;
wire [2:0] comp_keep;

wire [5:0] pol_v;
wire [5:0] cap_v;
wire [2:0] dgl_v;

wire wr_cfg;
wire wr_en;
wire wr_src;
wire reload_caps;

wire flag_clear;
wire [2:0] flag_set;

wire bus_cap_wake;
wire bus_cap_int;
wire timer_cap_wake;
wire timer_cap_int;

wire [15:0] cfg_view;
wire [15:0] en_view;
wire [15:0] flg_view;
wire [15:0] src_view;

// ----------------------------------------
// write decode
// ----------------------------------------
// the flags register has no strobe, so host writes to it are dropped
assign wr_cfg = reg_write && (reg_index == `IDX_WAKE_PIN_CONFIG);
assign wr_en = reg_write && (reg_index == `IDX_WAKE_PIN_ENABLE);
assign wr_src = reg_write && (reg_index == `IDX_WAKE_SOURCE_ENABLE);

// fail-safe entry outranks a host write in the same cycle
assign reload_caps = reset || fail_safe_entry; // R12

// ----------------------------------------
// configuration fields
// ----------------------------------------
wire [1:0] pin_a_polarity;
wire [1:0] pin_b_polarity;
wire [1:0] hv_io_polarity;

wire pin_a_deglitch_sel;
wire pin_b_deglitch_sel;
wire hv_io_deglitch_sel;

wire [1:0] pin_a_capability;
wire [1:0] pin_b_capability;
wire [1:0] hv_io_capability;

wire [1:0] bus_wake_capability;
wire [1:0] timer_wake_capability;

assign pin_a_polarity = cfg_q[`POL_A_LO+1:`POL_A_LO]; // R1
assign pin_b_polarity = cfg_q[`POL_B_LO+1:`POL_B_LO]; // R2
assign hv_io_polarity = cfg_q[`POL_HV_LO+1:`POL_HV_LO]; // R3

assign pin_a_deglitch_sel = cfg_q[`DGL_A_BIT]; // R4
assign pin_b_deglitch_sel = cfg_q[`DGL_B_BIT]; // R5
assign hv_io_deglitch_sel = cfg_q[`DGL_HV_BIT]; // R6

assign pin_a_capability = en_q[`CAP_A_LO+1:`CAP_A_LO]; // R7
assign pin_b_capability = en_q[`CAP_B_LO+1:`CAP_B_LO]; // R8
assign hv_io_capability = en_q[`CAP_HV_LO+1:`CAP_HV_LO]; // R9

assign bus_wake_capability = src_q[`CAP_BUS_LO+1:`CAP_BUS_LO]; // R10
assign timer_wake_capability = src_q[`CAP_TMR_LO+1:`CAP_TMR_LO]; // R11

// per pin vectors: index 0 pin a, 1 pin b, 2 hv io
assign pol_v = {hv_io_polarity, pin_b_polarity, pin_a_polarity};
assign cap_v = {hv_io_capability, pin_b_capability, pin_a_capability};
assign dgl_v = {hv_io_deglitch_sel, pin_b_deglitch_sel, pin_a_deglitch_sel};

// ----------------------------------------
// register storage
// ----------------------------------------

always @* begin
	cfg_d = cfg_q;
	if (wr_cfg) begin
		cfg_d = reg_wdata & `CFG_MASK; // R18
	end
end

always @* begin
	en_d = en_q;
	if (wr_en) begin
		en_d = reg_wdata & `EN_MASK; // R18
	end
end

always @* begin
	src_d = src_q;
	if (wr_src) begin
		src_d = reg_wdata & `SRC_MASK; // R10 R11
	end
end

always @(posedge clock) begin
	if (reset) begin
		cfg_q <= `CFG_RESET; // R1
	end else begin
		cfg_q <= cfg_d;
	end
end

always @(posedge clock) begin
	if (reload_caps) begin
		en_q <= `EN_RESET; // R12
	end else begin
		en_q <= en_d;
	end
end

always @(posedge clock) begin
	if (reload_caps) begin
		src_q <= `SRC_RESET; // R12
	end else begin
		src_q <= src_d;
	end
end

// ----------------------------------------
// per pin sync, deglitch and wake decode
// ----------------------------------------
genvar i;
generate
	for (i = 0; i < 3; i = i + 1) begin : g_pin
		reg s1_q;
		reg s2_q;
		reg filt_q;
		reg [`DGL_CNT_W-1:0] cnt_q;
		wire [`DGL_CNT_W-1:0] limit;
		wire [1:0] pol;
		wire [`DGL_CNT_W-1:0] last;
		wire mode_hit;

		assign pol = pol_v[2*i+1:2*i];
		assign limit = dgl_v[i] ? `DGL_LONG_CYC : `DGL_SHORT_CYC; // R4 R5 R6
		assign last = limit - 1'b1;

		// two flops before anything reads the asynchronous pin
		always @(posedge clock) begin
			if (reset) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
			end else begin
				s1_q <= wake_pin_in[i];
				s2_q <= s1_q;
			end
		end

		// the new level must hold for the whole window before it is taken
		always @(posedge clock) begin
			if (reset) begin
				filt_q <= 1'b0;
				cnt_q <= {`DGL_CNT_W{1'b0}};
			end else if (s2_q == filt_q) begin
				cnt_q <= {`DGL_CNT_W{1'b0}};
			end else if (cnt_q >= last) begin
				filt_q <= s2_q; // R4 R5 R6
				cnt_q <= {`DGL_CNT_W{1'b0}};
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end

		// code 11 is reserved on pins a and b and only wakes the hv io pin
		assign mode_hit = (i == 2) && (pol == `POL_MODE) && mode_wake_sel; // R3
		assign level_hit[i] = (pol == `POL_HIGH && filt_q) ||
			(pol == `POL_LOW && !filt_q) ||
			mode_hit; // R1 R2 R17

		assign wake_hit[i] = level_hit[i] && cap_v[2*i+`CAP_WAKE_BIT]; // R17
		assign int_hit[i] = level_hit[i] && cap_v[2*i+`CAP_INT_BIT]; // R17
		assign comp_keep[i] = !(low_power && pol == `POL_OFF); // R1 R2 R3
	end
endgenerate

// ----------------------------------------
// pin request outputs
// ----------------------------------------
// registered so the requests are glitch free levels
always @(posedge clock) begin
	if (reset) begin
		pin_wake_req <= 3'h0;
		pin_int_req <= 3'h0;
		pin_comparator_on <= 3'h0;
	end else begin
		pin_wake_req <= wake_hit; // R17
		pin_int_req <= int_hit; // R17
		pin_comparator_on <= comp_keep; // R1 R2 R3
	end
end

// ----------------------------------------
// wake flags
// ----------------------------------------
// a wake in the same cycle as clear-all wins over the clear
assign flag_clear = wake_flags_clear_all; // R16
assign flag_set = pin_wake_req; // R13 R14 R15

always @* begin
	flg_d = flg_q;
	if (flag_clear) begin
		flg_d = 16'h0000; // R16
	end
	if (flag_set[0]) begin
		flg_d[`FLG_A_BIT] = 1'b1; // R13
	end
	if (flag_set[1]) begin
		flg_d[`FLG_B_BIT] = 1'b1; // R14
	end
	if (flag_set[2]) begin
		flg_d[`FLG_HV_BIT] = 1'b1; // R15
	end
	flg_d = flg_d & `FLG_MASK; // R18
end

always @(posedge clock) begin
	if (reset) begin
		flg_q <= 16'h0000; // R16
	end else begin
		flg_q <= flg_d;
	end
end

// ----------------------------------------
// bus and timer sources
// ----------------------------------------
assign bus_cap_wake = bus_wake_capability[`CAP_WAKE_BIT]; // R10
assign bus_cap_int = bus_wake_capability[`CAP_INT_BIT]; // R10
assign timer_cap_wake = timer_wake_capability[`CAP_WAKE_BIT]; // R11
assign timer_cap_int = timer_wake_capability[`CAP_INT_BIT]; // R11

always @(posedge clock) begin
	if (reset) begin
		bus_wake_req <= 1'b0;
		bus_int_req <= 1'b0;
	end else begin
		bus_wake_req <= bus_wake_event && bus_cap_wake; // R10
		bus_int_req <= bus_wake_event && bus_cap_int; // R10
	end
end

always @(posedge clock) begin
	if (reset) begin
		timer_wake_req <= 1'b0;
		timer_int_req <= 1'b0;
	end else begin
		timer_wake_req <= timer_wake_event && timer_cap_wake; // R11
		timer_int_req <= timer_wake_event && timer_cap_int; // R11
	end
end

// ----------------------------------------
// read path
// ----------------------------------------
// unused positions always read back as zero
assign cfg_view = cfg_q & `CFG_MASK; // R18
assign en_view = en_q & `EN_MASK; // R18
assign flg_view = flg_q & `FLG_MASK; // R18
assign src_view = src_q & `SRC_MASK; // R18

always @* begin
	case (reg_index)
	`IDX_WAKE_PIN_CONFIG: rdata_d = cfg_view;
	`IDX_WAKE_PIN_ENABLE: rdata_d = en_view;
	`IDX_WAKE_PIN_FLAGS: rdata_d = flg_view;
	`IDX_WAKE_SOURCE_ENABLE: rdata_d = src_view;
	default: rdata_d = 16'h0000;
	endcase
end

// read data lags the index by one clock
always @(posedge clock) begin
	if (reset) begin
		reg_rdata <= 16'h0000;
	end else begin
		reg_rdata <= rdata_d;
	end
end

endmodule
`default_nettype wire

// ===== bench/wake_pins.sv
`timescale 1ns/1ps
`default_nettype none
module wake_pins (
	input wire logic clock,
	input wire logic [2:0] lvl,
	output logic [2:0] pins
);
	always @(posedge clock) pins <= lvl;
endmodule
`default_nettype wire

// ===== bench/wake_checker_props.sv
`timescale 1ns/1ps
`default_nettype none
module wake_checker (
	input wire logic clock,
	input wire logic reset,
	input wire logic reg_write,
	input wire logic [1:0] reg_index,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic fail_safe_entry,
	input wire logic bus_wake_event,
	input wire logic bus_wake_req,
	input wire logic bus_int_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	property p_w0; reg_write && reg_index == 2'h0 ##1 reg_index == 2'h0 |=>
		reg_rdata == ($past(reg_wdata, 2) & 16'h0EFC); endproperty
	a_w0: assert property (p_w0) else $error("config");
	property p_w1; reg_write && !fail_safe_entry && reg_index == 2'h1 ##1 reg_index == 2'h1
		|=> reg_rdata == ($past(reg_wdata, 2) & 16'h00FC); endproperty
	a_w1: assert property (p_w1) else $error("enable");
	property p_w3; reg_write && !fail_safe_entry && reg_index == 2'h3 ##1 reg_index == 2'h3
		|=> reg_rdata == ($past(reg_wdata, 2) & 16'h0033); endproperty
	a_w3: assert property (p_w3) else $error("source");
	property p_mk; $past(reg_index) == 2'h2 |-> (reg_rdata & 16'hFFD9) == 16'h0000; endproperty
	a_mk: assert property (p_mk) else $error("flags");
	property p_f1; fail_safe_entry ##1 reg_index == 2'h1 |=> reg_rdata == 16'h0054; endproperty
	a_f1: assert property (p_f1) else $error("fs enable");
	property p_f3; fail_safe_entry ##1 reg_index == 2'h3 |=> reg_rdata == 16'h0001; endproperty
	a_f3: assert property (p_f3) else $error("fs source");
	property p_bw; bus_wake_req |-> $past(bus_wake_event); endproperty
	a_bw: assert property (p_bw) else $error("bus wake");
	property p_bi; bus_int_req |-> $past(bus_wake_event); endproperty
	a_bi: assert property (p_bi) else $error("bus int");
	c_w: cover property (bus_wake_req);
	c_i: cover property (bus_int_req);
	c_f: cover property (fail_safe_entry ##1 reg_index == 2'h3);
endmodule
bind wake_source_config_regs wake_checker i_chk (.*);
`default_nettype wire

// ===== bench/tb_wake_source_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_wake_source_config_regs;
	logic clock = 0, reset = 1, reg_write = 0, fail_safe_entry = 0, wake_flags_clear_all = 0;
	logic low_power = 0, mode_wake_sel = 0, bus_wake_event = 0, timer_wake_event = 0;
	logic [1:0] reg_index = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic [2:0] lvl = 0, wake_pin_in, pin_wake_req, pin_int_req, pin_comparator_on;
	logic bus_wake_req, bus_int_req, timer_wake_req, timer_int_req;
	logic [15:0] rv [4] = '{16'h0004, 16'h0054, 16'h0000, 16'h0001};
	logic [15:0] mv [4] = '{16'h0EFC, 16'h00FC, 16'h0000, 16'h0033};
	int n_mismatch = 0, n_tests = 0, n;
	wake_pins i_pins (.clock(clock), .lvl(lvl), .pins(wake_pin_in));
	wake_source_config_regs i_dut (.*);
	initial forever #20 clock = ~clock;
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: %h not %h", $time, s, e);
		end
	endtask
	task wr(input logic [1:0] i, input logic [15:0] d);
		@(posedge clock) reg_write <= 1'h1;
		reg_index <= i;
		reg_wdata <= d;
		@(posedge clock) reg_write <= 1'h0;
	endtask
	task rd(input logic [1:0] i, input logic [15:0] e);
		@(posedge clock) reg_index <= i;
		repeat (2) @(posedge clock);
		#1 chk(reg_rdata, e);
	endtask
	task wrap_up;
		$display("%0d tests, %0d mismatches", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task t_regs;
		for (int i = 0; i < 4; i++) begin
			rd(2'(i), rv[i]);
			wr(2'(i), 16'hFFFF);
			rd(2'(i), mv[i]);
		end
		$display("register test done");
	endtask
	task t_fs;
		for (int i = 1; i < 4; i += 2) begin
			@(posedge clock) fail_safe_entry <= 1'h1;
			@(posedge clock) fail_safe_entry <= 1'h0;
			reg_index <= 2'(i);
			rd(2'(i), rv[i]);
		end
		rd(0, 16'h0EFC);
		$display("fail-safe test done");
	endtask
	task t_ev;
		for (int c = 0; c < 4; c++) begin
			wr(3, 16'(c * 17));
			@(posedge clock) bus_wake_event <= 1'h1;
			timer_wake_event <= 1'h1;
			@(posedge clock) bus_wake_event <= 1'h0;
			timer_wake_event <= 1'h0;
			#1 chk(16'({bus_wake_req, bus_int_req, timer_wake_req, timer_int_req}),
				16'(c[0] * 10 + c[1] * 5));
		end
		$display("event test done");
	endtask
	task t_pin;
		wr(1, 16'h000C);
		wr(0, 16'h0004);
		@(posedge clock) lvl <= 3'h1;
		#1;
		for (n = 0; pin_wake_req !== 3'h1 && n < 2000; n++) #40;
		chk(16'(n > 375 && n < 390), 16'h0001);
		if (n == 2000) wrap_up;
		chk(16'(pin_int_req), 16'h0001);
		@(posedge clock) lvl <= 3'h0;
		repeat (400) @(posedge clock);
		rd(2, 16'h0002);
		@(posedge clock) wake_flags_clear_all <= 1'h1;
		@(posedge clock) wake_flags_clear_all <= 1'h0;
		rd(2, 16'h0000);
		$display("pin test done");
	endtask
	task t_pin2;
		wr(1, 16'h0070);
		wr(0, 16'h04D0);
		@(posedge clock) low_power <= 1'h1;
		repeat (2) @(posedge clock);
		#1 chk(16'(pin_comparator_on), 16'h0006);
		@(posedge clock) lvl <= 3'h2;
		#1;
		for (n = 0; pin_wake_req[1] !== 1'b1 && n < 3000; n++) #40;
		chk(16'(n > 1625 && n < 1640), 16'h0001);
		if (n == 3000) wrap_up;
		@(posedge clock) mode_wake_sel <= 1'h1;
		repeat (2) @(posedge clock);
		#1 chk(16'({pin_int_req, pin_wake_req}), 16'h0016);
		@(posedge clock) wake_flags_clear_all <= 1'h1;
		@(posedge clock) wake_flags_clear_all <= 1'h0;
		rd(2, 16'h0024);
		@(posedge clock) lvl <= 3'h0;
		mode_wake_sel <= 1'h0;
		low_power <= 1'h0;
		$display("long deglitch test done");
	endtask
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'h0;
		t_regs;
		t_fs;
		t_ev;
		t_pin;
		t_pin2;
		wrap_up;
	end
endmodule
`default_nettype wire
